/* File: verif/spic_line_model.sv */
// Far-side model: wired serial line and infrared transceiver
`timescale 1ns/10ps
`default_nettype none
module spic_line_model (
  input wire logic ref_clk,
  input wire logic rxBit,
  input wire logic echo,
  input wire logic comEnable,
  input wire logic infraredPinsTx,
  input wire logic infraredEnable,
  output logic comRx,
  output logic infraredPinsRx
);
  logic toggle_r = 1'b0;
  always @(posedge ref_clk) begin
    toggle_r <= ~toggle_r;
  end
  // Wired line idles high; an unrouted transceiver shows a changing level
  assign comRx = comEnable ? rxBit : 1'b1;
  assign infraredPinsRx = !infraredEnable ? toggle_r : (echo ? infraredPinsTx : rxBit);
endmodule // spic_line_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the second serial port configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cfgDevice = 8'h00, cfgIndex = 8'h00, cfgWdata = 8'h00, cfgRdata;
  logic cfgWrite = 1'b0, cfgRead = 1'b0, coreFirstWrite = 1'b0, coreSecondWrite = 1'b0;
  logic [5:0] coreFirstData = 6'h00, coreFirst;
  logic [1:0] coreSecondData = 2'h0, coreSecond;
  logic midiEnable, highSpeed, halfDuplex, devRx, comRx, comTx, comEnable;
  logic [2:0] uartMode;
  logic uart1Irq = 1'b0, uart1InterruptGate = 1'b0, uart2Irq = 1'b0, uart2InterruptGate = 1'b0;
  logic uart1IrqOut, uart1IrqOe, uart2IrqOut, uart2IrqOe;
  logic devTx = 1'b1, devTxBusy = 1'b0, devRxBusy = 1'b0, rxBit = 1'b1, echo = 1'b0;
  logic infraredPinsRx, infraredPinsTx, infraredEnable, a, b;
  logic [7:0] d, e;
  logic [7:0] expQ[$];
  int errors = 0;
  int samplesChecked = 0;

  spic_config #(.STEP_CYCLES(4)) spic_config_inst (.ref_clk, .rst_n, .cfgDevice, .cfgIndex,
    .cfgWrite, .cfgRead, .cfgWdata, .cfgRdata, .coreFirstWrite, .coreFirstData,
    .coreSecondWrite, .coreSecondData, .coreFirst, .coreSecond, .midiEnable, .highSpeed,
    .halfDuplex, .uartMode, .uart1Irq, .uart1InterruptGate, .uart2Irq, .uart2InterruptGate,
    .uart1IrqOut, .uart1IrqOe, .uart2IrqOut, .uart2IrqOe, .devTx, .devTxBusy, .devRxBusy,
    .devRx, .comRx, .comTx, .comEnable, .infraredPinsRx, .infraredPinsTx, .infraredEnable);
  spic_line_model spic_line_model_inst (.ref_clk, .rxBit, .echo, .comEnable, .infraredPinsTx,
    .infraredEnable, .comRx, .infraredPinsRx);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: pins %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkReg(input logic [7:0] got);
    logic [7:0] exp;
    exp = expQ.pop_front();
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: read %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] dev, input logic [7:0] idx, input logic [7:0] val);
    cfgDevice = dev;
    cfgIndex = idx;
    cfgWdata = val;
    cfgWrite = 1'b1;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
    coreFirstWrite = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] dev, input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back(exp);
    cfgDevice = dev;
    cfgIndex = idx;
    cfgRead = 1'b1;
    @(negedge ref_clk);
    cfgRead = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    forever begin
      @(posedge ref_clk);
      if (cfgRead === 1'b1) begin
        @(negedge ref_clk);
        chkReg(cfgRdata);
      end
    end
  end

  initial begin
    #100us;
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    void'($urandom(67));
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    rd(8'h05, 8'hF0, 8'h00);
    rd(8'h05, 8'hF1, 8'h00);
    rd(8'h05, 8'hF2, 8'h03);
    rd(8'h06, 8'hF0, 8'h00);
    d = 8'($urandom);
    wr(8'h05, 8'hF0, d);
    rd(8'h05, 8'hF0, {6'h00, d[1:0]});
    chk({6'h00, highSpeed, midiEnable}, {6'h00, d[1:0]});
    for (int k = 0; k < 32; k++) begin
      d = {k[4:0], 3'($urandom)};
      wr(8'h05, 8'hF1, d);
      rd(8'h05, 8'hF1, d);
      chk({uartMode, halfDuplex, 4'h0}, {d[5:3], d[1], 4'h0});
      chk({coreSecond, coreFirst}, d);
      devTx = 1'($urandom);
      rxBit = 1'($urandom);
      echo = 1'($urandom);
      repeat (3) @(negedge ref_clk);
      case (d[7:6])
        2'b00: e = {3'h0, 2'b10, devTx, 1'b0, rxBit};
        2'b01: e = {3'h0, 2'b01, 1'b1, devTx, (echo ? devTx : rxBit) ^ d[0]};
        default: e = {3'h0, 2'b00, 1'b1, 1'b0, 1'b1};
      endcase
      chk({3'h0, comEnable, infraredEnable, comTx, infraredPinsTx, devRx},
        e);
    end
    echo = 1'b0;
    d = 8'($urandom);
    {coreSecondData, coreFirstData} = d;
    coreFirstWrite = 1'b1;
    coreSecondWrite = 1'b1;
    @(negedge ref_clk);
    coreSecondWrite = 1'b0;
    coreFirstWrite = 1'b0;
    @(negedge ref_clk);
    rd(8'h05, 8'hF1, d);
    coreFirstData = ~d[5:0];
    coreFirstWrite = 1'b1;
    wr(8'h05, 8'hF1, d ^ 8'h5A);
    rd(8'h05, 8'hF1, d ^ 8'h5A);
    d = 8'($urandom_range(0, 100));
    wr(8'h05, 8'hF2, d);
    rd(8'h05, 8'hF2, d);
    wr(8'h05, 8'hF1, 8'h42);
    wr(8'h05, 8'hF2, 8'h02);
    rxBit = 1'b0;
    devTx = 1'b1;
    devTxBusy = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, devRx}, 8'h01);
    devTxBusy = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, devRx}, 8'h01);
    repeat (20) @(negedge ref_clk);
    chk({7'h00, devRx}, 8'h00);
    wr(8'h05, 8'hF2, 8'h00);
    devTxBusy = 1'b1;
    repeat (3) @(negedge ref_clk);
    devTxBusy = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h00, devRx}, 8'h00);
    devRxBusy = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h00, infraredPinsTx}, 8'h00);
    wr(8'h05, 8'hF1, 8'h40);
    repeat (3) @(negedge ref_clk);
    chk({7'h00, infraredPinsTx}, 8'h01);
    devRxBusy = 1'b0;
    for (int s = 0; s < 2; s++) begin
      d = {s[0], 5'h00, 2'($urandom)};
      wr(8'h04, 8'hF0, d);
      rd(8'h04, 8'hF0, d);
      for (int k = 0; k < 16; k++) begin
        {uart1InterruptGate, uart1Irq, uart2InterruptGate, uart2Irq} = k[3:0];
        repeat (2) @(negedge ref_clk);
        a = k[3] & k[2];
        b = k[1] & k[0];
        e = s ? {4'h0, a | b, k[3] | k[1], a | b, k[3] | k[1]} : {4'h0, a, k[3], b, k[1]};
        chk({4'h0, uart1IrqOut, uart1IrqOe, uart2IrqOut, uart2IrqOe}, e);
      end
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire

/* File: verilog/spic_blank_timer.sv */
// Half duplex blanking hold timer
`timescale 1ns/10ps
`default_nettype none
`include "spic_params.svh"
module spic_blank_timer #(
  parameter int STEP_CYCLES = `SPIC_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic [7:0] timeout,
  output logic blank
);
  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [7:0] steps_r, steps_nxt;
  logic blank_r, blank_nxt;
  logic [7:0] limit;

  always_comb begin
    limit = (timeout > `SPIC_HDTO_MAX) ? `SPIC_HDTO_MAX : timeout;
    pre_nxt = pre_r;
    steps_nxt = steps_r;
    if (busy) begin
      pre_nxt = '0;
      steps_nxt = limit;
    end else if (steps_r != 8'h00) begin
      if (pre_r == PRE_W'(STEP_CYCLES - 1)) begin
        pre_nxt = '0;
        steps_nxt = steps_r - 8'h01;
      end else begin
        pre_nxt = pre_r + PRE_W'(1);
      end
    end
    blank_nxt = busy | (steps_nxt != 8'h00);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
      steps_r <= 8'h00;
      blank_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      steps_r <= steps_nxt;
      blank_r <= blank_nxt;
    end
  end

  assign blank = blank_r;

  chk_blank_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy |=> blank) else $error("blank missing while busy");
  chk_zero_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!busy && $past(busy) && $past(timeout) == 8'h00 && timeout == 8'h00) |=> !blank)
    else $error("zero timeout still blanking");
  chk_step_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!busy && steps_r != 8'h00 && pre_r != PRE_W'(STEP_CYCLES - 1)) |=> steps_r == $past(steps_r))
    else $error("step counted early");
  chk_step_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    steps_r <= `SPIC_HDTO_MAX) else $error("hold count above limit");
endmodule // spic_blank_timer
`default_nettype wire

/* File: verilog/spic_config.sv */
// Second serial port configuration, interrupt sharing and pin routing
`timescale 1ns/10ps
`default_nettype none
`include "spic_params.svh"
module spic_config #(
  parameter int STEP_CYCLES = `SPIC_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] cfgDevice,
  input wire logic [7:0] cfgIndex,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  input wire logic coreFirstWrite,
  input wire logic [5:0] coreFirstData,
  input wire logic coreSecondWrite,
  input wire logic [1:0] coreSecondData,
  output logic [5:0] coreFirst,
  output logic [1:0] coreSecond,
  output logic midiEnable,
  output logic highSpeed,
  output logic halfDuplex,
  output logic [2:0] uartMode,
  input wire logic uart1Irq,
  input wire logic uart1InterruptGate,
  input wire logic uart2Irq,
  input wire logic uart2InterruptGate,
  output logic uart1IrqOut,
  output logic uart1IrqOe,
  output logic uart2IrqOut,
  output logic uart2IrqOe,
  input wire logic devTx,
  input wire logic devTxBusy,
  input wire logic devRxBusy,
  output logic devRx,
  input wire logic comRx,
  output logic comTx,
  output logic comEnable,
  input wire logic infraredPinsRx,
  output logic infraredPinsTx,
  output logic infraredEnable
);
  logic [7:0] mode1_r, mode1_nxt;
  logic [1:0] mode2_r, mode2_nxt;
  logic [7:0] irOpt_r, irOpt_nxt;
  logic [7:0] hdto_r, hdto_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic wrS1, wrS2;
  spic_pkg::spic_route_type route;

  // Configuration registers with shared storage for the core mirror
  always_comb begin
    wrS1 = cfgWrite && (cfgDevice == `SPIC_LDN_SERIAL1) && (cfgIndex == `SPIC_IDX_MODE);
    wrS2 = cfgWrite && (cfgDevice == `SPIC_LDN_SERIAL2);
    mode1_nxt = mode1_r;
    mode2_nxt = mode2_r;
    irOpt_nxt = irOpt_r;
    hdto_nxt = hdto_r;
    if (coreFirstWrite) begin
      irOpt_nxt[5:0] = coreFirstData;
    end
    if (coreSecondWrite) begin
      irOpt_nxt[7:6] = coreSecondData;
    end
    if (wrS1) begin
      mode1_nxt = {cfgWdata[`SPIC_BIT_SHARE], 5'h00, cfgWdata[1:0]};
    end
    if (wrS2) begin
      unique case (cfgIndex)
        `SPIC_IDX_MODE: mode2_nxt = cfgWdata[1:0];
        `SPIC_IDX_IROPT: irOpt_nxt = cfgWdata;
        `SPIC_IDX_HDTO: hdto_nxt = cfgWdata;
        default: ;
      endcase
    end
    rdata_nxt = rdata_r;
    if (cfgRead) begin
      rdata_nxt = 8'h00;
      if (cfgDevice == `SPIC_LDN_SERIAL1 && cfgIndex == `SPIC_IDX_MODE) begin
        rdata_nxt = mode1_r;
      end else if (cfgDevice == `SPIC_LDN_SERIAL2) begin
        unique case (cfgIndex)
          `SPIC_IDX_MODE: rdata_nxt = {6'h00, mode2_r};
          `SPIC_IDX_IROPT: rdata_nxt = irOpt_r;
          `SPIC_IDX_HDTO: rdata_nxt = hdto_r;
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode1_r <= `SPIC_RST_MODE;
      mode2_r <= 2'h0;
      irOpt_r <= `SPIC_RST_IROPT;
      hdto_r <= `SPIC_RST_HDTO;
      rdata_r <= 8'h00;
    end else begin
      mode1_r <= mode1_nxt;
      mode2_r <= mode2_nxt;
      irOpt_r <= irOpt_nxt;
      hdto_r <= hdto_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Interrupt pin drive
  logic irq1Out_r, irq1Out_nxt, irq1Oe_r, irq1Oe_nxt;
  logic irq2Out_r, irq2Out_nxt, irq2Oe_r, irq2Oe_nxt;
  logic shared;

  always_comb begin
    shared = mode1_r[`SPIC_BIT_SHARE];
    if (shared) begin
      irq1Oe_nxt = uart1InterruptGate | uart2InterruptGate;
      irq1Out_nxt = (uart1InterruptGate & uart1Irq) | (uart2InterruptGate & uart2Irq);
      irq2Oe_nxt = irq1Oe_nxt;
      irq2Out_nxt = irq1Out_nxt;
    end else begin
      irq1Oe_nxt = uart1InterruptGate;
      irq1Out_nxt = uart1InterruptGate & uart1Irq;
      irq2Oe_nxt = uart2InterruptGate;
      irq2Out_nxt = uart2InterruptGate & uart2Irq;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq1Out_r <= 1'b0;
      irq1Oe_r <= 1'b0;
      irq2Out_r <= 1'b0;
      irq2Oe_r <= 1'b0;
    end else begin
      irq1Out_r <= irq1Out_nxt;
      irq1Oe_r <= irq1Oe_nxt;
      irq2Out_r <= irq2Out_nxt;
      irq2Oe_r <= irq2Oe_nxt;
    end
  end

  // Half duplex blanking timers
  logic hdx, blankRx, blankTx;
  assign hdx = irOpt_r[`SPIC_BIT_HDX];

  spic_blank_timer #(.STEP_CYCLES(STEP_CYCLES)) u_txHold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .busy(hdx & devTxBusy),
    .timeout(hdto_r),
    .blank(blankRx)
  );

  spic_blank_timer #(.STEP_CYCLES(STEP_CYCLES)) u_rxHold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .busy(hdx & devRxBusy),
    .timeout(hdto_r),
    .blank(blankTx)
  );

  // Pin routing
  logic devRx_r, devRx_nxt, comTx_r, comTx_nxt, irTx_r, irTx_nxt;
  logic comEn_r, comEn_nxt, irEn_r, irEn_nxt;
  logic irRxLevel;

  always_comb begin
    route = spic_pkg::spic_route_type'(irOpt_r[`SPIC_MUX_LO +: 2]);
    irRxLevel = infraredPinsRx ^ irOpt_r[`SPIC_BIT_RXPOL];
    devRx_nxt = 1'b1;
    comTx_nxt = 1'b1;
    irTx_nxt = 1'b0;
    comEn_nxt = 1'b0;
    irEn_nxt = 1'b0;
    unique case (route)
      spic_pkg::SPIC_ROUTE_COM: begin
        comEn_nxt = 1'b1;
        comTx_nxt = devTx;
        devRx_nxt = comRx;
      end
      spic_pkg::SPIC_ROUTE_IR: begin
        irEn_nxt = 1'b1;
        irTx_nxt = devTx & ~(hdx & blankTx);
        devRx_nxt = (hdx & blankRx) ? 1'b1 : irRxLevel;
      end
      spic_pkg::SPIC_ROUTE_AUX, spic_pkg::SPIC_ROUTE_OFF: begin
        comEn_nxt = 1'b0;
        irEn_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      devRx_r <= 1'b1;
      comTx_r <= 1'b1;
      irTx_r <= 1'b0;
      comEn_r <= 1'b0;
      irEn_r <= 1'b0;
    end else begin
      devRx_r <= devRx_nxt;
      comTx_r <= comTx_nxt;
      irTx_r <= irTx_nxt;
      comEn_r <= comEn_nxt;
      irEn_r <= irEn_nxt;
    end
  end

  assign cfgRdata = rdata_r;
  assign coreFirst = irOpt_r[5:0];
  assign coreSecond = irOpt_r[7:6];
  assign midiEnable = mode2_r[`SPIC_BIT_MIDI];
  assign highSpeed = mode2_r[`SPIC_BIT_HS];
  assign halfDuplex = irOpt_r[`SPIC_BIT_HDX];
  assign uartMode = irOpt_r[`SPIC_MODE_LO +: 3];
  assign uart1IrqOut = irq1Out_r;
  assign uart1IrqOe = irq1Oe_r;
  assign uart2IrqOut = irq2Out_r;
  assign uart2IrqOe = irq2Oe_r;
  assign devRx = devRx_r;
  assign comTx = comTx_r;
  assign comEnable = comEn_r;
  assign infraredPinsTx = irTx_r;
  assign infraredEnable = irEn_r;

  chk_share_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    shared |=> (uart1IrqOut == uart2IrqOut) && (uart1IrqOe == uart2IrqOe)
      && uart1IrqOut == ($past(uart1InterruptGate & uart1Irq)
        | $past(uart2InterruptGate & uart2Irq)))
    else $error("shared interrupt pins wrong");
  chk_share_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!uart1InterruptGate && !uart2InterruptGate) |=> !uart1IrqOe && !uart2IrqOe)
    else $error("interrupt pin driven with gates clear");
  chk_separate_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !shared |=> uart2IrqOe == $past(uart2InterruptGate)
      && uart2IrqOut == $past(uart2Irq & uart2InterruptGate))
    else $error("separate interrupt pin wrong");
  chk_reserved_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgRead && cfgDevice == `SPIC_LDN_SERIAL2 && cfgIndex == `SPIC_IDX_MODE)
      |=> cfgRdata[7:2] == 6'h00)
    else $error("reserved mode bits read nonzero");
  chk_mirror_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrS2 && cfgIndex == `SPIC_IDX_IROPT) |=> {coreSecond, coreFirst} == $past(cfgWdata))
    else $error("option write missing from core copy");
  chk_core_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (coreFirstWrite && !wrS2) |=> uartMode == $past(coreFirstData[5:3]))
    else $error("core write missing from option register");
  chk_route_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irOpt_r[7] |=> !comEnable && !infraredEnable)
    else $error("pins active for reserved routing");
  chk_ir_polarity: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (route == spic_pkg::SPIC_ROUTE_IR && !hdx) |=> devRx == $past(infraredPinsRx ^ irOpt_r[0]))
    else $error("infrared receive polarity wrong");
  chk_tx_blank: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (route == spic_pkg::SPIC_ROUTE_IR && hdx && blankTx) |=> !infraredPinsTx)
    else $error("infrared transmit not blanked");

  cov_shared: cover property (@(posedge ref_clk) disable iff (!rst_n) shared && uart2IrqOut);
  cov_ir_route: cover property (@(posedge ref_clk) disable iff (!rst_n) infraredEnable && hdx);
  cov_hold: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(devTxBusy) ##1 blankRx);
endmodule // spic_config
`default_nettype wire

/* File: verilog/spic_params.svh */
// Constants for the second serial port configuration block
// Function
// - Shared mode drives both interrupt pins with OR of gated UART interrupts.
// - First port mode bit 7 selects separate (0) or shared (1) interrupts.
// - Second port mode bit 0 enables MIDI; clear at reset.
// - Second port mode bit 1 enables high speed; clear at reset.
// - Infrared option bit 0 sets receive polarity: 0 high, 1 low.
// - Infrared option bit 1 selects full duplex (0) or half duplex (1).
// - Infrared option bits 5:3 select the port mode, eight codes.
// - Infrared option bits 7:6 route device: 00 wired pins, 01 infrared.
// - Routing codes 10 and 11 leave both pin sets inactive.
// - Timeout register sets half duplex turnaround, 100 us steps to 10 ms.
// - Zero blanks only while busy; N extends blanking by N steps.
// - Option bits mirror the infrared core's two configuration fields.
// - Writes to either copy update both, shared storage; last write wins, and a configuration write beats a core write in the same cycle.
`ifndef SPIC_PARAMS_SVH
`define SPIC_PARAMS_SVH
`define SPIC_LDN_SERIAL1 8'h04
`define SPIC_LDN_SERIAL2 8'h05
`define SPIC_IDX_MODE 8'hF0
`define SPIC_IDX_IROPT 8'hF1
`define SPIC_IDX_HDTO 8'hF2
`define SPIC_RST_MODE 8'h00
`define SPIC_RST_IROPT 8'h00
`define SPIC_RST_HDTO 8'h03
`define SPIC_BIT_MIDI 0
`define SPIC_BIT_HS 1
`define SPIC_BIT_SHARE 7
`define SPIC_BIT_RXPOL 0
`define SPIC_BIT_HDX 1
`define SPIC_MODE_LO 3
`define SPIC_MUX_LO 6
`define SPIC_HDTO_MAX 8'h64
`define SPIC_STEP_US 100
`define SPIC_CLK_MHZ 100
`define SPIC_STEP_CYCLES (`SPIC_STEP_US * `SPIC_CLK_MHZ)
`endif

/* File: verilog/spic_pkg.sv */
// Types for the second serial port configuration block
`default_nettype none
package spic_pkg;
  typedef enum logic [1:0] {
    SPIC_ROUTE_COM,
    SPIC_ROUTE_IR,
    SPIC_ROUTE_AUX,
    SPIC_ROUTE_OFF
  } spic_route_type;
  typedef enum logic [2:0] {
    SPIC_MODE_STD,
    SPIC_MODE_SIRA,
    SPIC_MODE_ASK,
    SPIC_MODE_SIRB,
    SPIC_MODE_HDLC,
    SPIC_MODE_PPM4,
    SPIC_MODE_CIR,
    SPIC_MODE_RAW
  } spic_mode_type;
endpackage
`default_nettype wire
